// ### hdl/fxa_regs.svh
// Function
// RULE1: host needs code flash programming mode first
// RULE2: write 0x01 to area select first
// RULE3: high and low data form one word
// RULE4: command code plus start bit starts command
// RULE5: 0x81 security word, 0x82 window word
// RULE6: further commands allowed while mode is held
// RULE7: always write whole four-byte word
// RULE8: bits 25..16 hold window end plus one
// RULE9: bits 9..0 hold window first block
// RULE10: bit 12 enables serial programming
// RULE11: bit 10 enables serial block erase
// RULE12: bit 9 enables boot area reprogramming
// RULE13: bit 8 picks boot cluster
// RULE14: boot flag change writes ones elsewhere
// RULE15: protect clear keeps boot flag as read
// RULE16: write protect restored only by chip erase
// RULE17: chip erase refused while protections cleared
// RULE18: poll completion bit before proceeding
// RULE19: read error flags after completion
// RULE20: monitor bit is inverse of boot flag
// RULE21: clear start, wait completion bit clear
// RULE22: extra command cannot be aborted
// RULE23: boot protect blocks boot flag change
// RULE24: security flags only move toward disabled
// RULE25: keep registers stable while command runs
// register map of the device as seen by this host
// assumes register indices picked by the host, since no offsets are fixed
`ifndef FXA_REGS_SVH
`define FXA_REGS_SVH
`define FXA_IDX_AREA 3'h0
`define FXA_IDX_WDH 3'h1
`define FXA_IDX_WDL 3'h2
`define FXA_IDX_CTRL 3'h3
`define FXA_IDX_STH 3'h4
`define FXA_IDX_STL 3'h5
`define FXA_AREA_EXTRA 16'h0001
`define FXA_CMD_SEC 8'h81
`define FXA_CMD_WIN 8'h82
`define FXA_CTRL_IDLE 16'h0000
`define FXA_DONE_BIT 7
`define FXA_MON_BIT 7
`define FXA_BIT_WRPROT 12
`define FXA_BIT_ERPROT 10
`define FXA_BIT_BTPROT 9
`define FXA_BIT_BOOT_SW 8
`endif

// ### hdl/fxa_pkg.sv
// types shared by the extra area host
// assumes a 16-bit device register port with one-cycle read latency
package fxa_pkg;
	typedef enum logic [1:0] {
		FXA_OP_WINDOW = 2'h0,
		FXA_OP_BOOT = 2'h1,
		FXA_OP_PROTECT = 2'h2
	} fxa_op_t;
	typedef struct packed {
		logic [2:0] addr;
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} fxa_req_t;
	typedef struct packed {
		logic [9:0] first;
		logic [9:0] end1;
		logic boot_val;
		logic [2:0] clr;
	} fxa_arg_t;
	typedef enum logic [3:0] {
		FXA_IDLE = 4'h0,
		FXA_FLG_RD = 4'h1,
		FXA_FLG_CK = 4'h3,
		FXA_SEL = 4'h2,
		FXA_WRH = 4'h6,
		FXA_WRL = 4'h7,
		FXA_GO = 4'h5,
		FXA_SET_RD = 4'h4,
		FXA_SET_CK = 4'hc,
		FXA_ERR_RD = 4'hd,
		FXA_ERR_CK = 4'hf,
		FXA_STOP = 4'he,
		FXA_CLR_RD = 4'ha,
		FXA_CLR_CK = 4'hb
	} fxa_st_t;
endpackage : fxa_pkg

// ### hdl/fxa_host.sv
// host sequencer that programs the flash extra area
// assumes the device register port runs on core_clk
`timescale 1ns/1ns
`include "fxa_regs.svh"
module fxa_host (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// user orders
	input wire logic op_valid,
	output logic op_ready,
	input wire fxa_pkg::fxa_op_t op_kind,
	input wire fxa_pkg::fxa_arg_t op_arg,
	input wire logic prog_mode,
	// user results
	output logic done,
	output logic refused,
	output logic [3:0] err_flags,
	// device register port
	output fxa_pkg::fxa_req_t dev_req,
	input wire logic [15:0] dev_rdata
);
	logic rst_s1_r;
	logic rst_n_r;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	fxa_pkg::fxa_st_t st_r, st_nxt;
	fxa_pkg::fxa_op_t kind_r, kind_nxt;
	fxa_pkg::fxa_arg_t arg_r, arg_nxt;
	logic flg_r, flg_nxt;
	logic [31:0] word_r, word_nxt;
	logic [3:0] err_r, err_nxt;
	logic done_r, done_nxt;
	logic ref_r, ref_nxt;
	fxa_pkg::fxa_req_t req_r, req_nxt;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n_r);

	// builds the whole 32-bit extra area word
	function automatic logic [31:0] build_word(
		input fxa_pkg::fxa_op_t k,
		input fxa_pkg::fxa_arg_t a,
		input logic flg
	);
		logic [31:0] w;
		w = 32'hffffffff;
		case (k)
			fxa_pkg::FXA_OP_WINDOW: begin
				w = {6'h00, a.end1, 6'h00, a.first}; // RULE8 RULE9
			end
			fxa_pkg::FXA_OP_BOOT: begin
				w[`FXA_BIT_BOOT_SW] = a.boot_val; // RULE13 RULE14
			end
			fxa_pkg::FXA_OP_PROTECT: begin
				// only clears are ever requested
				w[`FXA_BIT_WRPROT] = ~a.clr[2]; // RULE10 RULE24
				w[`FXA_BIT_ERPROT] = ~a.clr[1]; // RULE11 RULE24
				w[`FXA_BIT_BTPROT] = ~a.clr[0]; // RULE12 RULE24
				w[`FXA_BIT_BOOT_SW] = flg; // RULE15
			end
			default: begin
				w = 32'hffffffff;
			end
		endcase
		return w;
	endfunction : build_word

	// register request for a given state
	function automatic fxa_pkg::fxa_req_t req_of(
		input fxa_pkg::fxa_st_t s,
		input logic [31:0] w,
		input fxa_pkg::fxa_op_t k
	);
		fxa_pkg::fxa_req_t q;
		q = '0;
		case (s)
			fxa_pkg::FXA_FLG_RD: begin
				q.addr = `FXA_IDX_STL;
				q.rd = 1'b1;
			end
			fxa_pkg::FXA_SEL: begin
				q.addr = `FXA_IDX_AREA;
				q.wr = 1'b1;
				q.wdata = `FXA_AREA_EXTRA; // RULE2
			end
			fxa_pkg::FXA_WRH: begin
				q.addr = `FXA_IDX_WDH;
				q.wr = 1'b1;
				q.wdata = w[31:16]; // RULE3 RULE7
			end
			fxa_pkg::FXA_WRL: begin
				q.addr = `FXA_IDX_WDL;
				q.wr = 1'b1;
				q.wdata = w[15:0]; // RULE3 RULE7
			end
			fxa_pkg::FXA_GO: begin
				q.addr = `FXA_IDX_CTRL;
				q.wr = 1'b1;
				if (k == fxa_pkg::FXA_OP_WINDOW) begin
					q.wdata = {8'h00, `FXA_CMD_WIN}; // RULE4 RULE5
				end else begin
					q.wdata = {8'h00, `FXA_CMD_SEC}; // RULE4 RULE5
				end
			end
			fxa_pkg::FXA_SET_RD, fxa_pkg::FXA_CLR_RD: begin
				q.addr = `FXA_IDX_STH;
				q.rd = 1'b1;
			end
			fxa_pkg::FXA_ERR_RD: begin
				q.addr = `FXA_IDX_STL;
				q.rd = 1'b1;
			end
			fxa_pkg::FXA_STOP: begin
				q.addr = `FXA_IDX_CTRL;
				q.wr = 1'b1;
				q.wdata = `FXA_CTRL_IDLE; // RULE21
			end
			default: begin
				q = '0;
			end
		endcase
		return q;
	endfunction : req_of

	assign op_ready = (st_r == fxa_pkg::FXA_IDLE);

	always_comb begin
		st_nxt = st_r;
		kind_nxt = kind_r;
		arg_nxt = arg_r;
		flg_nxt = flg_r;
		err_nxt = err_r;
		done_nxt = 1'b0;
		ref_nxt = 1'b0;
		case (st_r)
			fxa_pkg::FXA_IDLE: begin
				if (op_valid) begin
					if (!prog_mode) begin
						ref_nxt = 1'b1; // RULE1
					end else begin
						// a new order may follow any finished one
						kind_nxt = op_kind; // RULE6
						arg_nxt = op_arg;
						if (op_kind == fxa_pkg::FXA_OP_PROTECT) begin
							st_nxt = fxa_pkg::FXA_FLG_RD;
						end else begin
							st_nxt = fxa_pkg::FXA_SEL;
						end
					end
				end
			end
			fxa_pkg::FXA_FLG_RD: begin
				st_nxt = fxa_pkg::FXA_FLG_CK;
			end
			fxa_pkg::FXA_FLG_CK: begin
				flg_nxt = ~dev_rdata[`FXA_MON_BIT]; // RULE20 RULE15
				st_nxt = fxa_pkg::FXA_SEL;
			end
			fxa_pkg::FXA_SEL: begin
				st_nxt = fxa_pkg::FXA_WRH;
			end
			fxa_pkg::FXA_WRH: begin
				st_nxt = fxa_pkg::FXA_WRL;
			end
			fxa_pkg::FXA_WRL: begin
				st_nxt = fxa_pkg::FXA_GO;
			end
			fxa_pkg::FXA_GO: begin
				st_nxt = fxa_pkg::FXA_SET_RD;
			end
			fxa_pkg::FXA_SET_RD: begin
				st_nxt = fxa_pkg::FXA_SET_CK;
			end
			fxa_pkg::FXA_SET_CK: begin
				// no abort path exists while the command runs
				if (dev_rdata[`FXA_DONE_BIT]) begin // RULE18 RULE22
					st_nxt = fxa_pkg::FXA_ERR_RD;
				end else begin
					st_nxt = fxa_pkg::FXA_SET_RD;
				end
			end
			fxa_pkg::FXA_ERR_RD: begin
				st_nxt = fxa_pkg::FXA_ERR_CK;
			end
			fxa_pkg::FXA_ERR_CK: begin
				err_nxt = dev_rdata[3:0]; // RULE19
				st_nxt = fxa_pkg::FXA_STOP;
			end
			fxa_pkg::FXA_STOP: begin
				st_nxt = fxa_pkg::FXA_CLR_RD;
			end
			fxa_pkg::FXA_CLR_RD: begin
				st_nxt = fxa_pkg::FXA_CLR_CK;
			end
			fxa_pkg::FXA_CLR_CK: begin
				if (!dev_rdata[`FXA_DONE_BIT]) begin // RULE21
					st_nxt = fxa_pkg::FXA_IDLE;
					done_nxt = 1'b1;
				end else begin
					st_nxt = fxa_pkg::FXA_CLR_RD;
				end
			end
			default: begin
				st_nxt = fxa_pkg::FXA_IDLE;
			end
		endcase
		// word stays fixed from data write to completion
		word_nxt = build_word(kind_nxt, arg_nxt, flg_nxt); // RULE25
		req_nxt = req_of(st_nxt, word_nxt, kind_nxt);
	end

	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= fxa_pkg::FXA_IDLE;
			kind_r <= fxa_pkg::FXA_OP_WINDOW;
			arg_r <= '0;
			flg_r <= 1'b1;
			word_r <= 32'h00000000;
			err_r <= 4'h0;
			done_r <= 1'b0;
			ref_r <= 1'b0;
			req_r <= '0;
		end else begin
			st_r <= st_nxt;
			kind_r <= kind_nxt;
			arg_r <= arg_nxt;
			flg_r <= flg_nxt;
			word_r <= word_nxt;
			err_r <= err_nxt;
			done_r <= done_nxt;
			ref_r <= ref_nxt;
			req_r <= req_nxt;
		end
	end

	assign dev_req = req_r;
	assign done = done_r;
	assign refused = ref_r;
	assign err_flags = err_r;

	// protocol checks on the user side and the device port
	mode_refuse_a: assert property ( // RULE1
		op_valid && op_ready && !prog_mode |=> refused && $stable(st_r))
		else $error("order taken outside programming mode");
	area_select_a: assert property ( // RULE2
		st_r == fxa_pkg::FXA_SEL |-> dev_req.wr && dev_req.addr == `FXA_IDX_AREA
		&& dev_req.wdata == `FXA_AREA_EXTRA ##1 st_r == fxa_pkg::FXA_WRH)
		else $error("extra area not selected before data");
	start_cmd_a: assert property ( // RULE4
		st_r == fxa_pkg::FXA_GO |-> dev_req.wr && dev_req.addr == `FXA_IDX_CTRL && dev_req.wdata[7]
		&& dev_req.wdata[2:0] != 3'h0 && $past(st_r) == fxa_pkg::FXA_WRL)
		else $error("bad start write");
	cmd_code_a: assert property ( // RULE5
		st_r == fxa_pkg::FXA_GO |-> dev_req.wdata[7:0] ==
		((kind_r == fxa_pkg::FXA_OP_WINDOW) ? `FXA_CMD_WIN : `FXA_CMD_SEC))
		else $error("wrong command code");
	win_word_a: assert property ( // RULE8
		st_r == fxa_pkg::FXA_WRH && kind_r == fxa_pkg::FXA_OP_WINDOW
		|-> dev_req.wdata == {6'h00, arg_r.end1} ##1 dev_req.wdata == {6'h00, arg_r.first})
		else $error("window word misplaced");
	boot_ones_a: assert property ( // RULE14
		st_r == fxa_pkg::FXA_WRL && kind_r == fxa_pkg::FXA_OP_BOOT
		|-> dev_req.wdata == {7'h7f, arg_r.boot_val, 8'hff} && $past(dev_req.wdata) == 16'hffff)
		else $error("boot flag word not padded with ones");
	stop_seq_a: assert property ( // RULE21
		st_r == fxa_pkg::FXA_SET_CK && dev_rdata[`FXA_DONE_BIT]
		|-> ##3 dev_req.wr && dev_req.addr == `FXA_IDX_CTRL && dev_req.wdata == 16'h0000)
		else $error("start not cleared after completion");
	done_late_a: assert property ( // RULE21
		done |-> $past(st_r) == fxa_pkg::FXA_CLR_CK && !$past(dev_rdata[`FXA_DONE_BIT]))
		else $error("done before handshake end");
	err_cap_a: assert property ( // RULE19
		st_r == fxa_pkg::FXA_ERR_CK |=> err_flags == $past(dev_rdata[3:0]))
		else $error("error flags not captured");
	word_hold_a: assert property ( // RULE25
		st_r == fxa_pkg::FXA_SET_CK |-> $stable(word_r) && !dev_req.wr)
		else $error("registers touched while running");
	half_order_a: assert property ( // RULE3 RULE7
		st_r == fxa_pkg::FXA_WRH |-> dev_req.wr && dev_req.addr == `FXA_IDX_WDH
		##1 dev_req.wr && dev_req.addr == `FXA_IDX_WDL)
		else $error("word halves out of order");
	flag_keep_a: assert property ( // RULE15 RULE20
		st_r == fxa_pkg::FXA_FLG_CK |=> flg_r == !$past(dev_rdata[`FXA_MON_BIT]))
		else $error("boot flag not taken from monitor");
	poll_again_a: assert property ( // RULE18 RULE22
		st_r == fxa_pkg::FXA_SET_CK && !dev_rdata[`FXA_DONE_BIT] |=> st_r == fxa_pkg::FXA_SET_RD)
		else $error("left polling before completion");
	protect_pad_a: assert property ( // RULE15
		st_r == fxa_pkg::FXA_WRL && kind_r == fxa_pkg::FXA_OP_PROTECT |-> dev_req.wdata[7:0] == 8'hff
		&& dev_req.wdata[`FXA_BIT_BOOT_SW] == flg_r && $past(dev_req.wdata) == 16'hffff)
		else $error("protect word not padded with ones");
	take_order_a: assert property ( // RULE1 RULE6
		op_valid && op_ready && prog_mode |=> !op_ready && !refused)
		else $error("order in programming mode not taken");
endmodule : fxa_host

// ### verif/fxa_dev.sv
// device model: extra area registers, sequencer and word store
// assumes one-cycle request pulses on core_clk
`timescale 1ns/1ns
module fxa_dev (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// register port
	input wire fxa_pkg::fxa_req_t dev_req,
	output logic [15:0] dev_rdata,
	// knobs and observed state
	input wire logic [3:0] lat,
	input wire logic [3:0] err,
	output logic [31:0] sec_q,
	output logic [31:0] win_q,
	output logic [31:0] last_w,
	output logic [7:0] nwr,
	output logic erase_ok
);
	logic [15:0] area_r, wdh_r, wdl_r, ctrl_r, q_r;
	logic [3:0] cnt_r, err_r;
	logic done_r, busy_r, shown_r;
	logic [31:0] w;
	assign w = {wdh_r, wdl_r};
	// serial chip erase only while erase and boot protections are enabled
	assign erase_ok = sec_q[10] && sec_q[9];
	// released read data is inverted, never held
	assign dev_rdata = shown_r ? q_r : ~q_r;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{area_r, wdh_r, wdl_r, ctrl_r, q_r, cnt_r, err_r} <= '0;
			{done_r, busy_r, shown_r, nwr, win_q, last_w} <= '0;
			sec_q <= 32'hffff_ffff;
		end else begin
			shown_r <= dev_req.rd;
			if (dev_req.rd) begin
				case (dev_req.addr)
					3'h4: q_r <= {8'h0, done_r, 7'h0};
					3'h5: q_r <= {8'h0, ~sec_q[8], 3'h0, err_r};
					default: q_r <= 16'h0;
				endcase
			end
			if (dev_req.wr) begin
				nwr <= nwr + 8'h1;
				case (dev_req.addr)
					3'h0: area_r <= dev_req.wdata;
					3'h1: wdh_r <= dev_req.wdata;
					3'h2: wdl_r <= dev_req.wdata;
					3'h3: begin
						ctrl_r <= dev_req.wdata;
						// a running command cannot be stopped
						if (dev_req.wdata[7] && !busy_r && !done_r) begin
							busy_r <= 1'b1;
							cnt_r <= lat;
						end
					end
					default: ;
				endcase
			end
			if (busy_r && cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
			if (busy_r && cnt_r == 4'h0) begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
				last_w <= w;
				err_r <= err;
				if (area_r[0] && ctrl_r[2:0] == 3'h1)
					sec_q <= (sec_q & w & 32'hffff_feff) | {23'h0, sec_q[9] ? w[8] : sec_q[8], 8'h0};
				if (area_r[0] && ctrl_r[2:0] == 3'h2) win_q <= w;
			end
			if (done_r && !ctrl_r[7]) done_r <= 1'b0;
		end
	end
endmodule : fxa_dev

// ### verif/fxa_host_tb.sv
// testbench: orders to the host, device model on the far side
// assumes 25 MHz core_clk
`timescale 1ns/1ns
module fxa_host_tb;
	logic core_clk, rst_b, op_valid, prog_mode, op_ready, done, refused;
	fxa_pkg::fxa_op_t op_kind;
	fxa_pkg::fxa_arg_t op_arg;
	logic [3:0] err_flags, lat, err;
	fxa_pkg::fxa_req_t dev_req;
	logic [15:0] dev_rdata;
	logic [31:0] sec_q, win_q, last_w;
	logic [7:0] nwr, n0;
	logic erase_ok;
	int miscompares, checked;
	fxa_host i_fxa_host (.core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid), .op_ready(op_ready),
		.op_kind(op_kind), .op_arg(op_arg), .prog_mode(prog_mode), .done(done), .refused(refused),
		.err_flags(err_flags), .dev_req(dev_req), .dev_rdata(dev_rdata));
	fxa_dev i_fxa_dev (.core_clk(core_clk), .rst_b(rst_b), .dev_req(dev_req), .dev_rdata(dev_rdata),
		.lat(lat), .err(err), .sec_q(sec_q), .win_q(win_q), .last_w(last_w), .nwr(nwr),
		.erase_ok(erase_ok));
	always #20 core_clk = ~core_clk;
	task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk_w
	task automatic chk_b(input string n, input logic [3:0] e, input logic [3:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk_b
	task automatic end_sim;
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// entered just after an edge; returns one step after done or refused
	task automatic order(input fxa_pkg::fxa_op_t k, input fxa_pkg::fxa_arg_t a);
		int n;
		n = 0;
		op_valid = 1'b1;
		op_kind = k;
		op_arg = a;
		while (op_ready !== 1'b1) begin
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		#1;
		op_valid = 1'b0;
		while (done !== 1'b1 && refused !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 400)
			miscompares++;
	endtask : order
	task automatic run(input fxa_pkg::fxa_op_t k, input fxa_pkg::fxa_arg_t a, input logic [3:0] e,
		input logic [3:0] l, input logic [31:0] w, input logic [31:0] s);
		err = e;
		lat = l;
		order(k, a);
		chk_b("done", 4'h1, {3'h0, done});
		chk_w("word", w, last_w);
		chk_w("security", s, sec_q);
		chk_b("errors", e, err_flags);
	endtask : run
	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		op_valid = 1'b0;
		prog_mode = 1'b1;
		op_kind = fxa_pkg::FXA_OP_WINDOW;
		op_arg = '0;
		lat = 4'h0;
		err = 4'h0;
		miscompares = 0;
		checked = 0;
		repeat (3) @(posedge core_clk);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		run(fxa_pkg::FXA_OP_WINDOW, {10'h3ff, 10'h001, 4'h0}, 4'h0, 4'h0, 32'h0001_03ff, 32'hffff_ffff);
		chk_b("chip erase", 4'h1, {3'h0, erase_ok});
		run(fxa_pkg::FXA_OP_WINDOW, {10'h000, 10'h3ff, 4'h0}, 4'h0, 4'h9, 32'h03ff_0000, 32'hffff_ffff);
		run(fxa_pkg::FXA_OP_BOOT, {20'h0, 4'h0}, 4'h0, 4'h3, 32'hffff_feff, 32'hffff_feff);
		run(fxa_pkg::FXA_OP_PROTECT, {20'h0, 4'h2}, 4'ha, 4'h0, 32'hffff_faff, 32'hffff_faff);
		run(fxa_pkg::FXA_OP_BOOT, {20'h0, 4'h8}, 4'h5, 4'h1, 32'hffff_ffff, 32'hffff_fbff);
		run(fxa_pkg::FXA_OP_PROTECT, {20'h0, 4'h1}, 4'h0, 4'h2, 32'hffff_fdff, 32'hffff_f9ff);
		run(fxa_pkg::FXA_OP_BOOT, {20'h0, 4'h0}, 4'h0, 4'h0, 32'hffff_feff, 32'hffff_f9ff);
		run(fxa_pkg::FXA_OP_PROTECT, {20'h0, 4'h4}, 4'h0, 4'h4, 32'hffff_efff, 32'hffff_e9ff);
		run(fxa_pkg::FXA_OP_BOOT, {20'h0, 4'h8}, 4'h0, 4'h0, 32'hffff_ffff, 32'hffff_e9ff);
		chk_b("chip erase", 4'h0, {3'h0, erase_ok});
		chk_w("window", 32'h03ff_0000, win_q);
		prog_mode = 1'b0;
		n0 = nwr;
		order(fxa_pkg::FXA_OP_WINDOW, '0);
		chk_b("refused", 4'h1, {3'h0, refused});
		chk_w("writes", {24'h0, n0}, {24'h0, nwr});
		end_sim;
	end
	initial begin
		#400000;
		miscompares++;
		end_sim;
	end
endmodule : fxa_host_tb
